// [verilog/tmr_edge_ctrl.sv]
// Timer edge detection, prescaler mode and output control register logic
`timescale 1ns/1ps
module tmr_edge_ctrl
   import tmr_edge_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Counter state and count clock enable
   input  wire logic       count_en,
   input  wire logic       count_tick,
   // Capture pins (asynchronous) and their edge selects
   input  wire logic       capture_input_first,
   input  wire logic       capture_input_n,
   input  wire logic [1:0] edge_sel_first,
   input  wire logic [1:0] edge_sel_n,
   // Prescaler mode register write
   input  wire logic       prm_wr,
   input  wire logic [7:0] prm_wdata,
   // Output control register access
   input  wire logic       oc_wr,
   input  wire logic [7:0] oc_wmask,
   input  wire logic [7:0] oc_wdata,
   // Results
   output logic [7:0]      prescaler_mode_reg,
   output logic [7:0]      oc_rdata,
   output logic            timer_output_enable_bit,
   output logic            one_shot_trigger,
   output logic            level_set_pulse,
   output logic            level_reset_pulse,
   output logic            edge_first,
   output logic            edge_n,
   output logic            prm_write_refused,
   output logic            trigger_too_soon
);
   logic [1:0] sync_first_q;
   logic [1:0] sync_n_q;
   logic [1:0] gap_q;
   logic       ospt_wr;

   // Two-stage synchronisers for the pins
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sync_first_q <= 2'h0;
         sync_n_q     <= 2'h0;
      end else begin
         sync_first_q <= {sync_first_q[0], capture_input_first};
         sync_n_q     <= {sync_n_q[0], capture_input_n};
      end
   end

   edge_detect u_edge_first (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .enable     (count_en),
      .edge_sel   (edge_sel_first),
      .pin_level  (sync_first_q[1]),
      .edge_pulse (edge_first)
   );

   edge_detect u_edge_n (
      .clk_sys    (clk_sys),
      .rst_n      (rst_n),
      .enable     (count_en),
      .edge_sel   (edge_sel_n),
      .pin_level  (sync_n_q[1]),
      .edge_pulse (edge_n)
   );

   // Prescaler mode write accepted only while stopped; running writes are dropped
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         prescaler_mode_reg <= PRM_RESET;
         prm_write_refused  <= 1'b0;
      end else begin
         prm_write_refused <= prm_wr & count_en;
         if (prm_wr && !count_en) begin
            prescaler_mode_reg <= prm_wdata;
         end
      end
   end

   assign ospt_wr = oc_wr & oc_wmask[OC_OSPT] & oc_wdata[OC_OSPT];

   // Enable bit is the only stored bit; masked writes leave it alone
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         timer_output_enable_bit <= OC_RESET[OC_TOE];
      end else if (oc_wr && oc_wmask[OC_TOE]) begin
         timer_output_enable_bit <= oc_wdata[OC_TOE];
      end
   end

   // Set, reset and trigger are pulses, never stored, so they read as zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         level_set_pulse   <= 1'b0;
         level_reset_pulse <= 1'b0;
         one_shot_trigger  <= 1'b0;
      end else begin
         level_set_pulse   <= oc_wr & oc_wmask[OC_LVS] & oc_wdata[OC_LVS];
         level_reset_pulse <= oc_wr & oc_wmask[OC_LVR] & oc_wdata[OC_LVR];
         one_shot_trigger  <= ospt_wr;
      end
   end

   // Readback: stored enable only
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         oc_rdata <= OC_RESET;
      end else begin
         oc_rdata <= OC_RESET;
         oc_rdata[OC_TOE] <= timer_output_enable_bit;
      end
   end

   // Count clock ticks since last trigger; flags a trigger arriving too soon
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gap_q            <= OSPT_GAP;
         trigger_too_soon <= 1'b0;
      end else begin
         trigger_too_soon <= ospt_wr & (gap_q < OSPT_GAP);
         if (ospt_wr) begin
            gap_q <= 2'h0;
         end else if (count_tick && gap_q < OSPT_GAP) begin
            gap_q <= gap_q + 2'h1;
         end
      end
   end
endmodule : tmr_edge_ctrl

// [include/tmr_edge_pkg.sv]
// Package of constants for the timer edge detect and output control block
package tmr_edge_pkg;
   // Valid edge selection codes
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_NONE = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // Output control register bit positions
   localparam int OC_LVR = 0;
   localparam int OC_LVS = 1;
   localparam int OC_TOE = 2;
   localparam int OC_OSPT = 3;
   localparam int OC_W = 8;
   localparam logic [7:0] OC_RESET = 8'h00;
   localparam logic [7:0] PRM_RESET = 8'h00;
   // Minimum spacing of one-shot triggers, in count clock ticks
   localparam logic [1:0] OSPT_GAP = 2'h2;
   // Previous level after reset
   localparam logic PREV_RESET = 1'b0;
endpackage : tmr_edge_pkg

// [verilog/edge_detect.sv]
// Capture pin edge detector with level hold across counter stop
`timescale 1ns/1ps
module edge_detect
   import tmr_edge_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   // Control
   input  wire logic       enable,
   input  wire logic [1:0] edge_sel,
   // Synchronised pin level
   input  wire logic       pin_level,
   // Result
   output logic            edge_pulse
);
   logic prev_q;
   logic rise;
   logic fall;

   // Previous level only tracks while running, so the compare at enable sees the change
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         prev_q <= PREV_RESET;
      end else if (enable) begin
         prev_q <= pin_level;
      end
   end

   assign rise = pin_level & ~prev_q;
   assign fall = ~pin_level & prev_q;

   // Edge pulse registered; stopped counter reports nothing
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         edge_pulse <= 1'b0;
      end else begin
         edge_pulse <= enable & (((edge_sel == EDGE_RISE || edge_sel == EDGE_BOTH) & rise) |
                                 ((edge_sel == EDGE_FALL || edge_sel == EDGE_BOTH) & fall));
      end
   end
endmodule : edge_detect

// [verification/tmr_chk_props.sv]
// Checker for the edge and output control block
`timescale 1ns/1ps
module tmr_chk import tmr_edge_pkg::*; (
   // Watched ports
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       count_en,
   input wire logic       edge_first,
   input wire logic       oc_wr,
   input wire logic [7:0] oc_wmask,
   input wire logic [7:0] oc_wdata,
   input wire logic [7:0] oc_rdata,
   input wire logic       timer_output_enable_bit,
   input wire logic       one_shot_trigger,
   input wire logic       level_set_pulse,
   input wire logic       level_reset_pulse,
   input wire logic [1:0] edge_sel_first,
   input wire logic       prm_wr,
   input wire logic [7:0] prescaler_mode_reg,
   input wire logic       prm_write_refused
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_rd; oc_rdata[OC_OSPT] == 1'b0 && oc_rdata[OC_LVS:OC_LVR] == 2'h0; endproperty
   a_rd: assert property (p_rd) else $error("rd");
   property p_tr; oc_wr && oc_wmask[OC_OSPT] && oc_wdata[OC_OSPT]
      |=> one_shot_trigger ##1 !one_shot_trigger; endproperty
   a_tr: assert property (p_tr) else $error("tr");
   property p_bit; oc_wr && timer_output_enable_bit && oc_wmask == 8'h02 && oc_wdata[OC_LVS]
      |=> level_set_pulse && timer_output_enable_bit; endproperty
   a_bit: assert property (p_bit) else $error("bit");
   property p_en; edge_first |-> $past(count_en); endproperty
   a_en: assert property (p_en) else $error("en");
   property p_lr; oc_wr && timer_output_enable_bit && oc_wmask == 8'h01 && oc_wdata[OC_LVR]
      |=> level_reset_pulse && timer_output_enable_bit; endproperty
   a_lr: assert property (p_lr) else $error("lr");
   property p_none; edge_sel_first == EDGE_NONE |=> !edge_first; endproperty
   a_none: assert property (p_none) else $error("none");
   property p_prm; prm_wr && count_en |=> prm_write_refused && $stable(prescaler_mode_reg);
   endproperty
   a_prm: assert property (p_prm) else $error("prm");
endmodule : tmr_chk
bind tmr_edge_ctrl tmr_chk chk (.*);

// [verification/pin_src.sv]
// Model of the external edge source pin
`timescale 1ns/1ps
module pin_src (
   // Clock, asked level and pin
   input  wire logic clk_sys,
   input  wire logic lvl,
   output logic      pin
);
   always_ff @(posedge clk_sys) pin <= lvl; // Follows lvl on each rising edge, one clock after it was asked
endmodule : pin_src

// [verification/tb_top.sv]
// Self-checking bench for the edge and output control block
`timescale 1ns/1ps
module tb_top import tmr_edge_pkg::*;;
   logic clk_sys = 0, rst_n = 0, count_en = 0, count_tick = 1, prm_wr = 0, oc_wr = 0, lvl = 1;
   logic pin, one_shot_trigger, level_set_pulse, level_reset_pulse, edge_first, edge_n;
   logic prm_write_refused, trigger_too_soon, timer_output_enable_bit;
   logic [1:0] edge_sel_first = EDGE_RISE;
   logic [7:0] oc_wmask = 0, wd = 0, prescaler_mode_reg, oc_rdata;
   int fails = 0, checked = 0;
   // Block and pin source; the second pin shares the first and watches both edges.
   // Counting runs from the tick port, never from the first pin, so no mode clash arises
   tmr_edge_ctrl uut (.capture_input_first(pin), .capture_input_n(pin),
      .edge_sel_n(EDGE_BOTH), .prm_wdata(wd), .oc_wdata(wd), .*);
   pin_src src (.*);
   initial forever #2 clk_sys = ~clk_sys; // 250 MHz
   task automatic chk(input logic [7:0] a, e);
      checked++;
      fails += int'(a !== e);
      if (a !== e) $display("BAD %0t got %h want %h", $time, a, e);
   endtask : chk
   // Bounded look for a pulse; e says whether it must come, a missing one ends the run
   task automatic wt(ref logic s, input logic e);
      int n;
      #1;
      for (n = 0; n < 9 && s !== 1'b1; n++) @(posedge clk_sys) #1;
      if (e && s !== 1'b1) begin
         fails++;
         $display("BAD %0t wait timed out", $time);
         conclude;
      end else begin
         chk({7'h0, s}, {7'h0, e});
      end
   endtask : wt
   task automatic wr(input logic p, input logic [7:0] m, d);
      @(posedge clk_sys);
      {prm_wr, oc_wr, oc_wmask, wd} <= {p, !p, m, d};
      @(posedge clk_sys);
      {prm_wr, oc_wr} <= 2'h0;
   endtask : wr
   // Stop, move the pin, re-enable and expect an edge
   // The both-edge second pin always answers; the first pin answers per its select
   task automatic go(input logic l, input logic [1:0] s, input logic e);
      @(posedge clk_sys);
      {count_en, lvl} <= {1'b0, l};
      repeat (6) @(posedge clk_sys);
      {edge_sel_first, count_en} <= {s, 1'b1};
      wt(edge_n, 1'b1);
      chk({7'h0, edge_first}, {7'h0, e});
   endtask : go
   task automatic conclude;
      $display("fails %0d checked %0d", fails, checked);
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1;
      go(1'b1, EDGE_RISE, 1'b1);
      go(1'b0, EDGE_FALL, 1'b1);
      go(1'b1, EDGE_RISE, 1'b1);
      go(1'b0, EDGE_NONE, 1'b0);
      go(1'b1, EDGE_BOTH, 1'b1);
      go(1'b0, EDGE_RISE, 1'b0);
      wr(0, 8'hFF, 8'h0E);
      wt(one_shot_trigger, 1'b1);
      // Readback register lags the enable bit by one cycle
      @(posedge clk_sys) #1;
      chk(oc_rdata, 8'h04);
      wr(0, 8'h02, 8'h02);
      wt(level_set_pulse, 1'b1);
      wr(0, 8'h01, 8'h01);
      wt(level_reset_pulse, 1'b1);
      chk({7'h0, timer_output_enable_bit}, 8'h01);
      // Triggers one tick apart, then one tick apart with ticks stopped after it, then three ticks apart
      wr(0, 8'h08, 8'h08);
      wr(0, 8'h08, 8'h08);
      wt(trigger_too_soon, 1'b1);
      @(posedge clk_sys);
      count_tick <= 1'b0;
      wr(0, 8'h08, 8'h08);
      wt(trigger_too_soon, 1'b1);
      @(posedge clk_sys);
      count_tick <= 1'b1;
      repeat (2) @(posedge clk_sys);
      wr(0, 8'h08, 8'h08);
      wt(trigger_too_soon, 1'b0);
      wr(1, 8'h00, 8'h5A);
      wt(prm_write_refused, 1'b1);
      chk(prescaler_mode_reg, 8'h00);
      @(posedge clk_sys);
      count_en <= 1'b0;
      wr(1, 8'h00, 8'hA5);
      #1 chk(prescaler_mode_reg, 8'hA5);
      chk({7'h0, prm_write_refused}, 8'h00);
      conclude;
   end
endmodule : tb_top
